/* epci_defs.svh */
// Constants for the external line and pin-change flag block: offsets, fields, reset values.
// Assumes a core that issues data-space and I/O-space byte accesses on one clock.
// What this block does
// R1: Line flags at 0x3C, bit1 line1, bit0 line0.
// R2: Line vectors need global bit and mask.
// R3: Vector execution clears its flag.
// R4: Writing one clears flag; zero keeps.
// R5: Low-level mode forces line flag read zero.
// R6: Low registers answer I/O address minus 0x20.
// R7: Extended registers reachable by data space only.
// R8: Enable bits 3:0 gate groups with global bit.
// R9: Enabled pin change raises its group vector.
// R10: Group flags at 0x3B bits 3:0.
// R11: Group vector needs global and group enable.
// R12: Group3 mask 0x73 bits 3:0, rest zero.
// R13: Group2 mask 0x6D all eight bits.
// R14: Group1 mask 0x6C bits 6:0, bit7 zero.
// R15: Group0 mask 0x6B all eight bits.
// R16: Masked-off pin never raises group request.
// R17: Sense 00 low,01 change,10 fall,11 rise.
// R18: Pin change caught without I/O clock; here a change is caught only through the synchroniser chain clocked by CLK.
// R19: Pulses over one clock always detected.
// R20: Hardware set beats software clear.
// R21: Everything resets zero; unused bits zero.
`ifndef EPCI_DEFS_SVH
`define EPCI_DEFS_SVH
`define EPCI_OFS_GFLAG   8'h3B
`define EPCI_OFS_LFLAG   8'h3C
`define EPCI_OFS_LMASK   8'h3D
`define EPCI_OFS_GEN     8'h68
`define EPCI_OFS_SENSE   8'h69
`define EPCI_OFS_GMASK0  8'h6B
`define EPCI_OFS_GMASK1  8'h6C
`define EPCI_OFS_GMASK2  8'h6D
`define EPCI_OFS_GMASK3  8'h73
`define EPCI_IO_BIAS     8'h20
`define EPCI_IO_TOP      8'h5F
`define EPCI_W_GMASK3    8'h0F
`define EPCI_W_GMASK1    8'h7F
`define EPCI_W_GEN       8'h0F
`define EPCI_W_SENSE     8'h0F
`define EPCI_W_LINE      8'h03
`define EPCI_RST8        8'h00
`endif

/* epci_pkg.sv */
// Types for the external line and pin-change flag block.
// Assumes the constants header is included by the design file.
package epci_pkg;
  typedef enum logic [1:0] {
    EPCI_LOW  = 2'b00,
    EPCI_ANY  = 2'b01,
    EPCI_FALL = 2'b10,
    EPCI_RISE = 2'b11
  } epci_sense_t;
endpackage

/* epci_top.sv */
// Flag, enable and mask logic for two external lines and four pin-change groups.
// Assumes the core issues one byte access per cycle and pulses a vector acknowledge per source.
`timescale 1ns/1ps
`include "epci_defs.svh"
module epci_top (
  // Clock and reset.
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  // Register access from the core.
  input  wire logic [7:0] ADDR,
  input  wire logic       IO_SPACE,
  input  wire logic       WR_EN,
  input  wire logic       RD_EN,
  input  wire logic [7:0] WDATA,
  output logic      [7:0] RDATA,
  output logic            RHIT,
  // Global interrupt bit from the core status register.
  input  wire logic       GLOBAL_IE,
  // External pins.
  input  wire logic       EXTERNAL_LINE_0,
  input  wire logic       EXTERNAL_LINE_1,
  input  wire logic [27:0] CHANGE_WATCHED_PIN,
  // Vector requests and acknowledges: bits 1:0 lines, bits 5:2 groups 0 to 3.
  output logic      [5:0] IRQ_REQ,
  input  wire logic [5:0] VEC_ACK
);

  // Synchronisers: first stage is read only by the second.
  logic [29:0] s1_q, s2_q, prev_q;
  logic [29:0] s1_d, s2_d, prev_d;
  logic [29:0] pins;
  assign pins = {CHANGE_WATCHED_PIN, EXTERNAL_LINE_1, EXTERNAL_LINE_0};

  // Priming: the chain resets to zero, so a pin that idles high would look like an edge.
  // Change detection stays blind until the chain and the previous sample both hold real pin values.
  logic [2:0] prime_q, prime_d;
  logic       primed;
  assign primed = prime_q[2];

  // Registers.
  logic [7:0] gmask0_q, gmask1_q, gmask2_q, gmask3_q, gen_q, lmask_q, sense_q;
  logic [7:0] gmask0_d, gmask1_d, gmask2_d, gmask3_d, gen_d, lmask_d, sense_d;
  logic [1:0] lflag_q, lflag_d;
  logic [3:0] gflag_q, gflag_d;
  logic [7:0] rdata_d;
  logic       rhit_d;

  // Effective data-space address; I/O-space accesses are biased and limited to the low window.
  logic [7:0] eff;
  logic       ok;
  assign eff = IO_SPACE ? 8'(ADDR + `EPCI_IO_BIAS) : ADDR; // R6
  assign ok  = IO_SPACE ? (ADDR <= 8'(`EPCI_IO_TOP - `EPCI_IO_BIAS)) : 1'b1; // R7

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs, input logic v);
    hit = v && (a == ofs);
  endfunction

  // Line request condition for one sense setting.
  function automatic logic line_evt(input logic [1:0] s, input logic cur, input logic prv);
    case (epci_pkg::epci_sense_t'(s))
      epci_pkg::EPCI_ANY:  line_evt = cur ^ prv;
      epci_pkg::EPCI_FALL: line_evt = prv & ~cur;
      epci_pkg::EPCI_RISE: line_evt = cur & ~prv;
      default:             line_evt = 1'b0;
    endcase
  endfunction

  // Change detection on the synchronised samples; one clock of width suffices.
  logic [27:0] chg;
  logic [3:0]  gevt;
  logic [1:0]  levt, llow;
  assign chg     = (s2_q[29:2] ^ prev_q[29:2]) & {28{primed}}; // R18 R19
  assign gevt[0] = |(chg[7:0]   & gmask0_q);        // R16 R9
  assign gevt[1] = |(chg[14:8]  & gmask1_q[6:0]);   // R16 R9
  assign gevt[2] = |(chg[23:16] & gmask2_q);        // R16 R9
  assign gevt[3] = |(chg[27:24] & gmask3_q[3:0]);   // R16 R9
  assign levt[0] = line_evt(sense_q[1:0], s2_q[0], prev_q[0]) & primed; // R17 R19
  assign levt[1] = line_evt(sense_q[3:2], s2_q[1], prev_q[1]) & primed; // R17 R19
  assign llow[0] = (sense_q[1:0] == 2'b00); // R5
  assign llow[1] = (sense_q[3:2] == 2'b00); // R5

  // Qualified strobes: an I/O-space access above the low window is dropped here.
  // Dropping it once, before any decode, keeps every register group below in agreement.
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = WR_EN & ok; // R7
  assign rd_ok = RD_EN & ok; // R7

  // One write strobe per register, so the configuration and flag groups share one decode.
  logic wr_gmask0;
  logic wr_gmask1;
  logic wr_gmask2;
  logic wr_gmask3;
  logic wr_gen;
  logic wr_lmask;
  logic wr_sense;
  logic wr_lflag;
  logic wr_gflag;
  assign wr_gmask0 = hit(eff, `EPCI_OFS_GMASK0, wr_ok); // R15
  assign wr_gmask1 = hit(eff, `EPCI_OFS_GMASK1, wr_ok); // R14
  assign wr_gmask2 = hit(eff, `EPCI_OFS_GMASK2, wr_ok); // R13
  assign wr_gmask3 = hit(eff, `EPCI_OFS_GMASK3, wr_ok); // R12
  assign wr_gen    = hit(eff, `EPCI_OFS_GEN, wr_ok);    // R8
  assign wr_lmask  = hit(eff, `EPCI_OFS_LMASK, wr_ok);
  assign wr_sense  = hit(eff, `EPCI_OFS_SENSE, wr_ok);
  assign wr_lflag  = hit(eff, `EPCI_OFS_LFLAG, wr_ok);  // R4
  assign wr_gflag  = hit(eff, `EPCI_OFS_GFLAG, wr_ok);  // R4

  // Synchroniser group: the chain simply follows the pins, and priming fills with ones.
  always_comb begin
    s1_d    = pins;
    s2_d    = s1_q;
    prev_d  = s2_q;
    prime_d = {prime_q[1:0], 1'b1};
  end

  // The chain clears on reset; priming keeps that cleared state from counting as a change.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s1_q    <= '0;
      s2_q    <= '0;
      prev_q  <= '0;
      prime_q <= '0;
    end else begin
      s1_q    <= s1_d;
      s2_q    <= s2_d;
      prev_q  <= prev_d;
      prime_q <= prime_d;
    end
  end

  // Configuration group: pin masks, group enables, line masks and sense fields.
  // Unimplemented bits are trimmed on the way in, so they can never read back as one.
  always_comb begin
    gmask0_d = gmask0_q;
    gmask1_d = gmask1_q;
    gmask2_d = gmask2_q;
    gmask3_d = gmask3_q;
    gen_d    = gen_q;
    lmask_d  = lmask_q;
    sense_d  = sense_q;
    if (wr_gmask0) begin
      gmask0_d = WDATA; // R15
    end
    if (wr_gmask1) begin
      gmask1_d = WDATA & `EPCI_W_GMASK1; // R14
    end
    if (wr_gmask2) begin
      gmask2_d = WDATA; // R13
    end
    if (wr_gmask3) begin
      gmask3_d = WDATA & `EPCI_W_GMASK3; // R12
    end
    if (wr_gen) begin
      gen_d = WDATA & `EPCI_W_GEN; // R8
    end
    if (wr_lmask) begin
      lmask_d = WDATA & `EPCI_W_LINE;
    end
    if (wr_sense) begin
      sense_d = WDATA & `EPCI_W_SENSE;
    end
  end

  // Configuration registers clear on reset, which leaves both lines in low-level mode, masked off.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      gmask0_q <= `EPCI_RST8; // R21
      gmask1_q <= `EPCI_RST8;
      gmask2_q <= `EPCI_RST8;
      gmask3_q <= `EPCI_RST8;
      gen_q    <= `EPCI_RST8;
      lmask_q  <= `EPCI_RST8;
      sense_q  <= `EPCI_RST8;
    end else begin
      gmask0_q <= gmask0_d;
      gmask1_q <= gmask1_d;
      gmask2_q <= gmask2_d;
      gmask3_q <= gmask3_d;
      gen_q    <= gen_d;
      lmask_q  <= lmask_d;
      sense_q  <= sense_d;
    end
  end

  // Flag group: a vector acknowledge and a write of one both clear, and a new event wins over both.
  // The set is ORed in after the clear so that a request arriving in the clearing cycle is kept.
  logic [1:0] lclr;
  logic [3:0] gclr;
  always_comb begin
    lclr = VEC_ACK[1:0]; // R3
    gclr = VEC_ACK[5:2]; // R3
    if (wr_lflag) begin
      lclr = lclr | WDATA[1:0]; // R4
    end
    if (wr_gflag) begin
      gclr = gclr | WDATA[3:0]; // R4
    end
    lflag_d = ((lflag_q & ~lclr) | levt) & ~llow; // R1 R20 R5
    gflag_d = (gflag_q & ~gclr) | gevt; // R10 R20
  end

  // Flags clear on reset; nothing is pending until a pin event is seen.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      lflag_q <= '0; // R21
      gflag_q <= '0;
    end else begin
      lflag_q <= lflag_d;
      gflag_q <= gflag_d;
    end
  end

  // Read group: one mux on the effective address; unmapped or refused reads return zero.
  // Returning zero when idle lets the core OR several blocks' read buses together.
  always_comb begin
    rhit_d  = rd_ok;
    rdata_d = `EPCI_RST8;
    unique case (eff)
      `EPCI_OFS_GFLAG: begin
        rdata_d = {4'h0, gflag_q}; // R10
      end
      `EPCI_OFS_LFLAG: begin
        rdata_d = {6'h00, lflag_q}; // R1
      end
      `EPCI_OFS_LMASK: begin
        rdata_d = lmask_q;
      end
      `EPCI_OFS_GEN: begin
        rdata_d = gen_q;
      end
      `EPCI_OFS_SENSE: begin
        rdata_d = sense_q;
      end
      `EPCI_OFS_GMASK0: begin
        rdata_d = gmask0_q;
      end
      `EPCI_OFS_GMASK1: begin
        rdata_d = gmask1_q;
      end
      `EPCI_OFS_GMASK2: begin
        rdata_d = gmask2_q;
      end
      `EPCI_OFS_GMASK3: begin
        rdata_d = gmask3_q;
      end
      default: begin
        rhit_d = 1'b0;
      end
    endcase
    if (!rd_ok) begin
      rhit_d  = 1'b0;
      rdata_d = `EPCI_RST8;
    end
  end

  // Read data is registered, so it stands for exactly the cycle after the read strobe.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RDATA <= `EPCI_RST8; // R21
      RHIT  <= 1'b0;
    end else begin
      RDATA <= rdata_d;
      RHIT  <= rhit_d;
    end
  end

  // Requests: level mode requests while the synchronised pin is low, without a flag.
  logic [1:0] lreq;
  assign lreq = lflag_q | (llow & ~s2_q[1:0]); // R5
  assign IRQ_REQ[1:0] = {2{GLOBAL_IE}} & lmask_q[1:0] & lreq; // R2
  assign IRQ_REQ[5:2] = {4{GLOBAL_IE}} & gen_q[3:0] & gflag_q; // R11 R8
endmodule

/* epci_monitor.sv */
// Checker on the top ports of the flag block.
// Assumes one clock and the synchronous reset.
`timescale 1ns/1ps
module epci_monitor (
  // Clock, reset, bus and requests.
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic [7:0]  ADDR,
  input wire logic        IO_SPACE,
  input wire logic        RD_EN,
  input wire logic [7:0]  RDATA,
  input wire logic        RHIT,
  input wire logic        GLOBAL_IE,
  input wire logic [27:0] CHANGE_WATCHED_PIN,
  input wire logic [5:0]  IRQ_REQ,
  input wire logic [5:0]  VEC_ACK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Quiet group 0 pins leave the acknowledge as the only thing acting on the flag.
  sequence s_quiet; $stable(CHANGE_WATCHED_PIN[7:0]) [*4]; endsequence
  sequence s_ack0; IRQ_REQ[2] && VEC_ACK[2]; endsequence
  a_io_refused: assert property (RD_EN && IO_SPACE && ADDR > 8'h3F |=> !RHIT) else $error("io hit");
  a_io_alias: assert property (RD_EN && IO_SPACE && ADDR == 8'h1C |=> RHIT && RDATA[7:2] == 6'h00) else $error("alias");
  a_grp3_width: assert property (RD_EN && !IO_SPACE && ADDR == 8'h73 |=> RDATA[7:4] == 4'h0) else $error("g3");
  a_grp1_width: assert property (RD_EN && !IO_SPACE && ADDR == 8'h6C |=> !RDATA[7]) else $error("g1");
  a_gflag_width: assert property (RD_EN && IO_SPACE && ADDR == 8'h1B |=> RDATA[7:4] == 4'h0) else $error("gf");
  a_gie_gate: assert property (!GLOBAL_IE |-> IRQ_REQ == 6'h00) else $error("gie");
  a_ack_clears: assert property (s_quiet ##0 s_ack0 |=> !IRQ_REQ[2]) else $error("ack");
  a_idle_read: assert property (!RD_EN |=> RDATA == 8'h00 && !RHIT) else $error("idle");
endmodule
bind epci_top epci_monitor mon (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .IO_SPACE(IO_SPACE), .RD_EN(RD_EN),
  .RDATA(RDATA), .RHIT(RHIT), .GLOBAL_IE(GLOBAL_IE), .CHANGE_WATCHED_PIN(CHANGE_WATCHED_PIN),
  .IRQ_REQ(IRQ_REQ), .VEC_ACK(VEC_ACK));

/* epci_core.sv */
// Core model: acknowledges the lowest pending request.
// Assumes the block's request levels.
`timescale 1ns/1ps
module epci_core (
  // Clock, enable, requests, acknowledges.
  input  wire logic       clk,
  input  wire logic       ack_on,
  input  wire logic [5:0] irq_req,
  output logic      [5:0] vec_ack
);
  // A gap after each pulse lets the flag fall first.
  always_ff @(posedge clk) vec_ack <= (ack_on && vec_ack == 6'h00) ? irq_req & -irq_req : 6'h00;
endmodule

/* tb.sv */
// Testbench: registers, pin groups, lines 0 and 1.
// Assumes the monitor binds itself.
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, rst = 1'b1, io = 1'b0, wr = 1'b0, rd = 1'b0, gie = 1'b0, l0 = 1'b1, l1 = 1'b1;
  logic        ack_on = 1'b0, rhit;
  logic [7:0]  addr = 8'h00, wd = 8'h00, rdata;
  logic [27:0] pins = 28'h000_0000;
  logic [5:0]  irq, ack;
  int          err_count = 0, checks = 0, cycles = 0;
  // Clock and both sides of the block.
  always #12.5 clk = ~clk;
  epci_top dut (.CLK(clk), .SYS_RST(rst), .ADDR(addr), .IO_SPACE(io), .WR_EN(wr), .RD_EN(rd), .WDATA(wd),
    .RDATA(rdata), .RHIT(rhit), .GLOBAL_IE(gie), .EXTERNAL_LINE_0(l0), .EXTERNAL_LINE_1(l1),
    .CHANGE_WATCHED_PIN(pins), .IRQ_REQ(irq), .VEC_ACK(ack));
  epci_core core (.clk(clk), .ack_on(ack_on), .irq_req(irq), .vec_ack(ack));
  // The run needs under two hundred cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One access; a read is judged while its answer stands, then the bus idles.
  task automatic acc(input logic w, input logic sp, input logic [7:0] a, input logic [7:0] d, input logic h);
    io = sp;
    addr = a;
    wd = d;
    wr = w;
    rd = !w;
    cyc(1);
    wr = 1'b0;
    rd = 1'b0;
    if (!w) chk("read", {h, d}, {rhit, rdata});
    cyc(1);
  endtask
  // Mask reset values and widths; I/O space must not reach them.
  task automatic t_masks;
    logic [7:0] ofs [4] = '{8'h6B, 8'h6C, 8'h6D, 8'h73};
    logic [7:0] wid [4] = '{8'hFF, 8'h7F, 8'hFF, 8'h0F};
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 1'b0, ofs[i], 8'h00, 1'b1);
      acc(1'b1, 1'b0, ofs[i], 8'hFF, 1'b0);
      acc(1'b0, 1'b0, ofs[i], wid[i], 1'b1);
      acc(1'b0, 1'b1, ofs[i] - 8'h20, 8'h00, 1'b0);
    end
  endtask
  // Masked pin ignored; each group flags; write-one clears; acknowledge clears.
  task automatic t_groups;
    gie = 1'b1;
    acc(1'b1, 1'b0, 8'h68, 8'h0F, 1'b0);
    acc(1'b1, 1'b0, 8'h6B, 8'h01, 1'b0);
    pins[1] = 1'b1;
    cyc(5);
    acc(1'b0, 1'b1, 8'h1B, 8'h00, 1'b1);
    pins = pins ^ 28'h101_0101;
    cyc(5);
    chk("irq", 9'h03C, {3'b000, irq});
    acc(1'b0, 1'b1, 8'h1B, 8'h0F, 1'b1);
    acc(1'b1, 1'b1, 8'h1B, 8'h05, 1'b0);
    acc(1'b0, 1'b0, 8'h3B, 8'h0A, 1'b1);
    acc(1'b1, 1'b1, 8'h1B, 8'h0A, 1'b0);
    ack_on = 1'b1;
    pins[0] = 1'b0;
    cyc(8);
    acc(1'b0, 1'b1, 8'h1B, 8'h00, 1'b1);
    ack_on = 1'b0;
  endtask
  // Lines 0 and 1 in every sense mode; level mode leaves both flags clear.
  task automatic t_line;
    acc(1'b1, 1'b1, 8'h1D, 8'h03, 1'b0);
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, 1'b0, 8'h69, {4'h0, m[1:0], m[1:0]}, 1'b0);
      acc(1'b1, 1'b1, 8'h1C, 8'h03, 1'b0);
      l0 = 1'b0;
      l1 = 1'b0;
      cyc(5);
      acc(1'b0, 1'b1, 8'h1C, {6'h00, (m == 1 || m == 2), (m == 1 || m == 2)}, 1'b1);
      chk("irq", {7'h00, (m != 3), (m != 3)}, {7'h00, irq[1:0]});
      acc(1'b1, 1'b0, 8'h3C, 8'h03, 1'b0);
      l0 = 1'b1;
      l1 = 1'b1;
      cyc(5);
      chk("irq", {7'h00, (m == 1 || m == 3), (m == 1 || m == 3)}, {7'h00, irq[1:0]});
      acc(1'b1, 1'b0, 8'h3C, 8'h03, 1'b0);
    end
  endtask
  // Reset for 16 cycles, then the scenarios.
  initial begin
    cyc(16);
    rst = 1'b0;
    cyc(1);
    t_masks();
    t_groups();
    t_line();
    report_and_stop();
  end
endmodule
